// File: shared/fast_timer_pkg.sv
// Constants for the fast timer with compare units and dead-time pairs.
// Assumes one 100 MHz system clock and a classic Wishbone register port.
`default_nettype none
package fast_timer_pkg;
  localparam int DW = 8;
  localparam int NCH = 3;
  // Register byte offsets
  localparam logic [7:0] ADR_CTRL_A  = 8'h00; // pwm/wave/invert
  localparam logic [7:0] ADR_CTRL_B  = 8'h04; // clock select, clear
  localparam logic [7:0] ADR_COUNTER = 8'h08;
  localparam logic [7:0] ADR_CMP0    = 8'h0c; // channels at 0c,10,14
  localparam logic [7:0] ADR_TOP     = 8'h18;
  localparam logic [7:0] ADR_DEAD    = 8'h1c;
  localparam logic [7:0] ADR_FLAGS   = 8'h20;
  localparam logic [7:0] ADR_PLL     = 8'h24;
  localparam logic [7:0] ADR_FORCE   = 8'h28;
  localparam logic [7:0] ADR_DTPS    = 8'h2c;
  localparam logic [7:0] ADR_STEP    = 8'h04;
  // Field positions
  localparam int B_PWM_EN   = 0;  // ctrl_a
  localparam int B_WAVE0    = 1;  // ctrl_a waveform_mode 2 bits
  localparam int B_INVERT   = 3;  // ctrl_a pwm_invert
  localparam int B_OMODE0   = 4;  // dtps output_mode ch n at bits 8+2n (B_OMODE0 unused)
  localparam int B_PSCLR    = 7;  // ctrl_b prescaler_clear
  localparam int B_ACLK_EN  = 0;  // pll async_clock_enable
  localparam int B_LOWSPD   = 1;  // pll low_speed_select
  localparam int B_LOCKED   = 2;  // pll pll_locked (input)
  localparam int B_OVF      = 3;  // flags overflow_flag
  localparam int PSC_W      = 14;
  localparam int PSC_MAXSEL = 15;
  // Fast clock rates in MHz
  localparam int FAST_MHZ = 64;
  localparam int SLOW_MHZ = 32;
  localparam logic [7:0] RST_VAL = 8'h00;
  localparam logic [7:0] TOP_RST = 8'hff;
  localparam logic [1:0] OM_COMPL = 2'b01;
  localparam logic [1:0] OM_TOGGLE = 2'b01;
  localparam logic [1:0] OM_CLEAR = 2'b10;
  localparam logic [1:0] OM_SET = 2'b11;
  localparam logic [1:0] WM_FAST = 2'b00;
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ACK  = 2'b01
  } bus_state_t;
endpackage : fast_timer_pkg
`default_nettype wire

// File: src/fast_timer.sv
// Fast timer: prescaler, 8-bit counter, three compare units, dead time.
// Assumes a classic Wishbone master and a fast clock enable from outside.
//
// Notes on behaviour
// - Counting base is system clock, or fast clock enable when async enabled.
// - Clock select gives base, divides to 1/16384, and stop.
// - Fast clock runs 64 MHz, or 32 MHz with low speed select.
// - Writing prescaler clear resets the prescaler.
// - Each tick the counter clears, increments or decrements per mode.
// - Clock select zero stops; counter stays readable and writable.
// - CPU counter write beats any clear or count that cycle.
// - Equality with compare sets flag on the next tick.
// - Compare flags clear by service or by writing one; overflow flag by writing one.
// - PWM modes buffer compare writes to top/bottom; normal writes direct.
// - Reading compare returns the latest written value.
// - Force strobe acts like a match on waveform only, non-PWM.
// - Counter write blocks compare matches in the next tick.
// - Output mode acts at once; outputs hold over mode changes.
// - Three dead-time generators give complementary pairs, PWM and mode 01.
// - Dead-time prescaler divides tick by 1, 2, 4 or 8.
// - 4-bit down counter delays each rising output by its nibble.
// - Outputs lag waveform by at least one tick.
// - Invert bit inverts both outputs of a dead-time pair only; both high in dead time.
// - Top register sets wrap value in normal and fast PWM.
// - Reset forces every compare output to zero.
`timescale 1ns/1ns
`default_nettype none
module fast_timer (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_fast_tick,
  input  wire logic       i_pll_locked,
  input  wire logic       i_irq_ack,
  input  wire logic [1:0] i_irq_ack_ch,
  input  wire logic       i_wb_cyc,
  input  wire logic       i_wb_stb,
  input  wire logic       i_wb_we,
  input  wire logic [7:0] i_wb_adr,
  input  wire logic [3:0] i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output logic [31:0]     o_wb_dat,
  output logic            o_wb_ack,
  output logic [2:0]      o_cmp_out,
  output logic [2:0]      o_cmp_out_n,
  output logic            o_low_speed
);
  import fast_timer_pkg::*;

  logic [7:0] ctrl_a_q, ctrl_b_q, ctrl_om_q, top_q, top_buf_q, dead_q;
  logic [7:0] count_q, pll_q;
  logic [1:0] dtps_q;
  logic [7:0] cmp_q [NCH];
  logic [7:0] cmp_buf_q [NCH];
  logic [NCH-1:0] flag_q, wave_q;
  logic ovf_q, block_q, dir_down_q;
  logic [PSC_W-1:0] psc_q;
  bus_state_t bus_q;

  // Bus request decode
  logic wr, rd_go, base_tick, tick, pwm_on;
  logic wr_cnt, wr_flags, wr_force, wr_psclr;
  assign rd_go  = i_wb_cyc && i_wb_stb && (bus_q == BUS_IDLE);
  assign wr     = rd_go && i_wb_we && i_wb_sel[0];
  assign wr_cnt   = wr && (i_wb_adr == ADR_COUNTER);
  assign wr_flags = wr && (i_wb_adr == ADR_FLAGS);
  assign wr_force = wr && (i_wb_adr == ADR_FORCE);
  assign wr_psclr = wr && (i_wb_adr == ADR_CTRL_B) && i_wb_dat[B_PSCLR];
  assign pwm_on = ctrl_a_q[B_PWM_EN];

  function automatic logic is_cmp(input logic [7:0] a, input int n);
    is_cmp = (a == ADR_CMP0 + 8'(n) * ADR_STEP);
  endfunction : is_cmp

  // Prescaler base: system clock or fast enable pulse
  assign base_tick = pll_q[B_ACLK_EN] ? i_fast_tick : 1'b1;
  // Divider chain; rollover bits give the power-of-two taps
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      psc_q <= '0;
    end else if (wr_psclr) begin
      psc_q <= '0;
    end else if (base_tick) begin
      psc_q <= psc_q + 1'b1;
    end
  end

  // Tick select: 0 stop, 1 undivided, n divides by 2^(n-1)
  always_comb begin
    logic [3:0] cs;
    cs = ctrl_b_q[3:0];
    if (cs == 4'h0) begin
      tick = 1'b0;
    end else if (cs == 4'h1) begin
      tick = base_tick;
    end else begin
      tick = base_tick && (psc_q[cs-4'd2 +: 1] == 1'b1)
             && (psc_q & ((PSC_W'(1) << (cs - 4'd2)) - PSC_W'(1))) ==
                PSC_W'((PSC_W'(1) << (cs - 4'd2)) - PSC_W'(1));
    end
  end

  // Counter: phase correct mode counts up then down
  logic at_top, at_bot, upd_pt;
  assign at_top = (count_q == top_q);
  assign at_bot = (count_q == RST_VAL);
  assign upd_pt = pwm_on ? (ctrl_a_q[B_WAVE0] ? at_bot : at_top) : 1'b0;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      count_q <= RST_VAL;
      dir_down_q <= 1'b0;
    end else if (wr_cnt) begin
      count_q <= i_wb_dat[7:0];
    end else if (tick) begin
      if (pwm_on && ctrl_a_q[B_WAVE0]) begin
        if (dir_down_q) begin
          count_q <= count_q - 1'b1;
          if (count_q == 8'h01) dir_down_q <= 1'b0;
        end else if (at_top) begin
          count_q <= count_q - 1'b1;
          dir_down_q <= 1'b1;
        end else begin
          count_q <= count_q + 1'b1;
        end
      end else if (at_top) begin
        count_q <= RST_VAL;
      end else begin
        count_q <= count_q + 1'b1;
      end
    end
  end

  // Block matches in the tick after a counter write
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      block_q <= 1'b0;
    end else if (wr_cnt) begin
      block_q <= 1'b1;
    end else if (tick) begin
      block_q <= 1'b0;
    end
  end

  // Overflow flag on a tick at top (wrap or phase correct turn); write one clears, set wins
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ovf_q <= 1'b0;
    end else if (tick && at_top && !wr_cnt) begin
      ovf_q <= 1'b1;
    end else if (wr_flags && i_wb_dat[B_OVF]) begin
      ovf_q <= 1'b0;
    end
  end

  // Control registers; output mode applies at once
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_a_q  <= RST_VAL;
      ctrl_b_q  <= RST_VAL;
      ctrl_om_q <= RST_VAL;
      dead_q    <= RST_VAL;
      pll_q     <= RST_VAL;
      dtps_q    <= 2'b00;
    end else if (wr) begin
      unique case (i_wb_adr)
        ADR_CTRL_A: ctrl_a_q  <= i_wb_dat[7:0];
        ADR_CTRL_B: ctrl_b_q  <= {1'b0, i_wb_dat[6:0]};
        ADR_DTPS:   ctrl_om_q <= i_wb_dat[15:8];
        ADR_DEAD:   dead_q    <= i_wb_dat[7:0];
        ADR_PLL:    pll_q     <= {6'b0, i_wb_dat[1:0]};
        default:    ;
      endcase
      if (i_wb_adr == ADR_DTPS) dtps_q <= i_wb_dat[1:0];
    end
  end

  // Top register, buffered in PWM modes like the compare registers
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      top_q <= TOP_RST;
      top_buf_q <= TOP_RST;
    end else begin
      if (wr && i_wb_adr == ADR_TOP) begin
        top_buf_q <= i_wb_dat[7:0];
        if (!pwm_on) top_q <= i_wb_dat[7:0];
      end else if (pwm_on && tick && upd_pt) begin
        top_q <= top_buf_q;
      end
    end
  end

  // Per-channel compare, flag and waveform
  for (genvar n = 0; n < NCH; n++) begin : g_ch
    logic match, cmp_wr;
    logic [1:0] om;
    assign om = ctrl_om_q[2*n +: 2];
    assign cmp_wr = wr && is_cmp(i_wb_adr, n);
    assign match = (count_q == cmp_q[n]) && !block_q;
    // Compare buffer: direct in normal mode
    always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
        cmp_q[n] <= RST_VAL;
        cmp_buf_q[n] <= RST_VAL;
      end else if (cmp_wr) begin
        cmp_buf_q[n] <= i_wb_dat[7:0];
        if (!pwm_on) cmp_q[n] <= i_wb_dat[7:0];
      end else if (pwm_on && tick && upd_pt) begin
        cmp_q[n] <= cmp_buf_q[n];
      end
    end
    // Flag set on tick after equality; set beats clear
    always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
        flag_q[n] <= 1'b0;
      end else if (tick && match) begin
        flag_q[n] <= 1'b1;
      end else if ((wr_flags && i_wb_dat[n]) ||
                   (i_irq_ack && i_irq_ack_ch == 2'(n))) begin
        flag_q[n] <= 1'b0;
      end
    end
    // Waveform; force acts only outside PWM and sets no flag
    always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
        wave_q[n] <= 1'b0;
      end else if (pwm_on) begin
        if (tick && match && om != 2'b00) begin
          wave_q[n] <= (om == OM_SET);
        end else if (tick && at_top && !ctrl_a_q[B_WAVE0] && om != 2'b00) begin
          wave_q[n] <= (om != OM_SET);
        end
      end else if ((tick && match) || (wr_force && i_wb_dat[n])) begin
        unique case (om)
          OM_TOGGLE: wave_q[n] <= !wave_q[n];
          OM_CLEAR:  wave_q[n] <= 1'b0;
          OM_SET:    wave_q[n] <= 1'b1;
          default:   wave_q[n] <= wave_q[n];
        endcase
      end
    end
  end

  // Dead-time prescaler by 1,2,4,8
  logic [2:0] dtp_q;
  logic dt_tick;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      dtp_q <= 3'b000;
    end else if (tick) begin
      dtp_q <= dtp_q + 1'b1;
    end
  end
  assign dt_tick = tick &&
    ((dtp_q & ((3'b001 << dtps_q) - 3'b001)) == ((3'b001 << dtps_q) - 3'b001));

  // Dead-time generators; outputs start low at reset
  for (genvar n = 0; n < NCH; n++) begin : g_dt
    logic [3:0] cnt_q;
    logic prev_q, compl;
    assign compl = pwm_on && (ctrl_om_q[2*n +: 2] == OM_COMPL);
    always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
        cnt_q <= 4'h0;
        prev_q <= 1'b0;
        o_cmp_out[n] <= 1'b0;
        o_cmp_out_n[n] <= 1'b0;
      end else if (tick) begin // output lags waveform a tick
        prev_q <= wave_q[n];
        if (!compl) begin
          o_cmp_out[n] <= wave_q[n];
          o_cmp_out_n[n] <= !wave_q[n];
        end else if (wave_q[n] != prev_q) begin
          cnt_q <= wave_q[n] ? dead_q[7:4] : dead_q[3:0];
          // Both off (or both high when inverted) during dead time
          o_cmp_out[n] <= ctrl_a_q[B_INVERT];
          o_cmp_out_n[n] <= ctrl_a_q[B_INVERT];
        end else if (cnt_q != 4'h0) begin
          if (dt_tick) cnt_q <= cnt_q - 1'b1;
        end else begin
          o_cmp_out[n] <= wave_q[n] ^ ctrl_a_q[B_INVERT];
          o_cmp_out_n[n] <= !wave_q[n] ^ ctrl_a_q[B_INVERT];
        end
      end
    end
  end

  // Wishbone slave: ack one cycle after request, then drop
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      bus_q <= BUS_IDLE;
      o_wb_ack <= 1'b0;
      o_wb_dat <= '0;
      o_low_speed <= 1'b0;
    end else begin
      o_low_speed <= pll_q[B_LOWSPD];
      if (rd_go) begin
        bus_q <= BUS_ACK;
        o_wb_ack <= 1'b1;
        unique case (i_wb_adr)
          ADR_CTRL_A:  o_wb_dat <= {24'h0, ctrl_a_q};
          ADR_CTRL_B:  o_wb_dat <= {24'h0, ctrl_b_q};
          ADR_COUNTER: o_wb_dat <= {24'h0, count_q};
          ADR_TOP:     o_wb_dat <= {24'h0, top_buf_q};
          ADR_DEAD:    o_wb_dat <= {24'h0, dead_q};
          ADR_FLAGS:   o_wb_dat <= {28'h0, ovf_q, flag_q};
          ADR_PLL:     o_wb_dat <= {29'h0, i_pll_locked, pll_q[1:0]};
          ADR_DTPS:    o_wb_dat <= {16'h0, ctrl_om_q, 6'h0, dtps_q};
          default: begin
            o_wb_dat <= '0;
            for (int k = 0; k < NCH; k++) begin
              if (is_cmp(i_wb_adr, k)) o_wb_dat <= {24'h0, cmp_buf_q[k]};
            end
          end
        endcase
      end else begin
        bus_q <= BUS_IDLE;
        o_wb_ack <= 1'b0;
      end
    end
  end

  // Checks; a match in the write cycle itself is not blocked
  sequence cnt_write_s;
    wr_cnt && !flag_q[0] && !(tick && g_ch[0].match);
  endsequence
  sequence next_tick_s;
    tick && !wr_cnt && !i_irq_ack;
  endsequence
  chk_write_wins: assert property (@(posedge i_clk)
    disable iff (i_rst) wr_cnt |=> count_q == $past(i_wb_dat[7:0]))
    else $error("counter write lost");
  chk_stop_holds: assert property (@(posedge i_clk)
    disable iff (i_rst)
    (ctrl_b_q[3:0] == 4'h0 && !wr_cnt) |=> $stable(count_q))
    else $error("stopped counter moved");
  chk_flag_set: assert property (@(posedge i_clk)
    disable iff (i_rst) (tick && g_ch[0].match) |=> flag_q[0])
    else $error("flag not set on match");
  chk_flag_block: assert property (@(posedge i_clk)
    disable iff (i_rst) cnt_write_s ##1 next_tick_s |=> !flag_q[0])
    else $error("match not blocked");
  chk_reset_out: assert property (@(posedge i_clk)
    i_rst |=> o_cmp_out == 3'b000)
    else $error("outputs not cleared at reset");
  chk_pair_nonover: assert property (@(posedge i_clk)
    disable iff (i_rst) !ctrl_a_q[B_INVERT] && g_dt[0].compl
      |-> !(o_cmp_out[0] && o_cmp_out_n[0]))
    else $error("pair overlaps");
  chk_psc_clear: assert property (@(posedge i_clk)
    disable iff (i_rst) wr_psclr |=> psc_q == '0)
    else $error("prescaler not cleared");
  chk_direct_cmp: assert property (@(posedge i_clk)
    disable iff (i_rst)
    (g_ch[0].cmp_wr && !pwm_on) |=> cmp_q[0] == cmp_buf_q[0])
    else $error("normal mode compare not direct");
  chk_ack_pulse: assert property (@(posedge i_clk)
    disable iff (i_rst) o_wb_ack |=> !o_wb_ack)
    else $error("ack held");
endmodule : fast_timer
`default_nettype wire

// File: sim/switch_pair_model.sv
// Model of the external power switch legs on the compare outputs.
// Assumes both switches of a leg sample on the system clock edge.
`timescale 1ns/1ns
`default_nettype none
module switch_pair_model (
  input  wire logic        i_clk,
  input  wire logic        i_clear,
  input  wire logic [2:0]  i_hi,
  input  wire logic [2:0]  i_lo,
  input  wire logic        i_active_low,
  output logic [15:0]      o_overlaps
);
  logic [2:0] on_hi;
  logic [2:0] on_lo;
  // A switch conducts at its active level
  assign on_hi = i_active_low ? ~i_hi : i_hi;
  assign on_lo = i_active_low ? ~i_lo : i_lo;
  // Both switches of one leg on shorts the supply
  always @(posedge i_clk) begin
    if (i_clear)
      o_overlaps <= 16'h0000;
    else if ((on_hi & on_lo) != 3'b000)
      o_overlaps <= o_overlaps + 16'h0001;
  end
endmodule : switch_pair_model
`default_nettype wire

// File: sim/test_fast_timer.sv
// Bench for the fast timer: registers, counting, compare, dead time.
// Assumes the register map and one-cycle ack of the Wishbone port.
`timescale 1ns/1ns
`default_nettype none
module test_fast_timer;
  import fast_timer_pkg::*;
  logic        i_clk, i_rst, i_fast_tick, fast_on, cyc, stb, we;
  logic        i_irq_ack, ack, low_speed, inv, clr;
  logic [1:0]  i_irq_ack_ch, ph;
  logic [7:0]  adr;
  logic [31:0] wdat, rdat, q;
  logic [2:0]  out, out_n;
  logic [15:0] overlaps;
  int          errors, tests_run, g, seen;

  fast_timer u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_fast_tick(i_fast_tick),
    .i_pll_locked(1'b1), .i_irq_ack(i_irq_ack), .i_irq_ack_ch(i_irq_ack_ch),
    .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
    .i_wb_sel(4'hf), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
    .o_cmp_out(out), .o_cmp_out_n(out_n), .o_low_speed(low_speed));
  switch_pair_model u_sw (.i_clk(i_clk), .i_clear(clr), .i_hi(out),
    .i_lo(out_n), .i_active_low(inv), .o_overlaps(overlaps));

  // Free running system clock
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  // Fast clock stand-in: an enable every fourth cycle, so no second
  // domain exists and the half-rate limit has nothing to guard
  always @(posedge i_clk) begin
    if (i_rst) begin
      ph <= 2'd0;
      i_fast_tick <= 1'b0;
    end else begin
      ph <= ph + 2'd1;
      i_fast_tick <= fast_on && (ph == 2'd0);
    end
  end

  task automatic cmp(input logic [31:0] got, exp, input string what);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : cmp
  // One classic cycle; waits for ack without assuming its latency
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge i_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (ack !== 1'b1 && n < 64);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 64) cmp(0, 1, "no ack");
  endtask : wb
  task automatic rd(input logic [7:0] a, input logic [31:0] e, string s);
    wb(1'b0, a, 32'h0);
    cmp(q, e, s);
  endtask : rd
  // Cycles until one output of channel 0 reaches a level
  task automatic wait_lvl(input bit neg, input logic v);
    g = 0;
    while ((neg ? out_n[0] : out[0]) !== v && g < 600) begin
      @(posedge i_clk);
      g++;
    end
  endtask : wait_lvl
  // Run counter from 0 for a span, then stop it
  task automatic run_cs(input logic [7:0] cs, input int span);
    wb(1, ADR_CTRL_B, 32'h0);
    wb(1, ADR_COUNTER, 32'h0);
    wb(1, ADR_CTRL_B, {24'h0, cs});
    repeat (span) @(posedge i_clk);
    wb(1, ADR_CTRL_B, 32'h0);
    wb(0, ADR_COUNTER, 32'h0);
  endtask : run_cs

  task automatic t_reset;
    cmp({out, out_n}, 0, "outputs after reset");
    rd(ADR_TOP, TOP_RST, "top reset");
    rd(ADR_COUNTER, 32'h0, "counter reset");
    rd(8'h3c, 32'h0, "unmapped read");
    wb(1, ADR_COUNTER, 32'h5a);
    repeat (20) @(posedge i_clk);
    rd(ADR_COUNTER, 32'h5a, "stopped counter");
  endtask : t_reset

  task automatic t_prescale;
    run_cs(8'h8f, 100);
    cmp(q, 0, "slowest select");
    run_cs(8'h82, 40);
    cmp(q >= 19 && q <= 23, 1, "divide by two");
    wb(1, ADR_TOP, 32'h3);
    wb(1, ADR_FLAGS, 32'hf);
    run_cs(8'h01, 30);
    cmp(q <= 3, 1, "wrap at top");
    rd(ADR_FLAGS, 32'hf, "overflow and matches");
    wb(1, ADR_TOP, 32'hff);
  endtask : t_prescale

  task automatic t_match;
    wb(1, ADR_FLAGS, 32'hf);
    wb(1, ADR_CMP0, 32'h5);
    wb(1, ADR_COUNTER, 32'h5);
    wb(1, ADR_CTRL_B, 32'h1);
    wb(1, ADR_CTRL_B, 32'h0);
    rd(ADR_FLAGS, 32'h0, "blocked match");
    wb(1, ADR_CTRL_B, 32'h1);
    wb(1, ADR_COUNTER, 32'h5);
    wb(1, ADR_CTRL_B, 32'h0);
    rd(ADR_FLAGS, 32'h0, "blocked while running");
    for (int i = 0; i < 2; i++) begin
      wb(1, ADR_COUNTER, 32'h3);
      wb(1, ADR_CTRL_B, 32'h1);
      repeat (10) @(posedge i_clk);
      wb(1, ADR_CTRL_B, 32'h0);
      rd(ADR_FLAGS, 32'h1, "match flag");
      if (i == 0) wb(1, ADR_FLAGS, 32'h1);
      else begin
        i_irq_ack <= 1'b1;
        @(posedge i_clk);
        i_irq_ack <= 1'b0;
      end
      rd(ADR_FLAGS, 32'h0, "flag cleared");
    end
  endtask : t_match

  task automatic t_force;
    wb(1, ADR_CMP0, 32'hf0);
    wb(1, ADR_TOP, 32'h3);
    wb(1, ADR_DTPS, 32'h0100);
    wb(1, ADR_CTRL_B, 32'h1);
    for (int i = 1; i >= 0; i--) begin
      wb(1, ADR_FORCE, 32'h1);
      repeat (4) @(posedge i_clk);
      cmp(out[0], i, "forced toggle");
    end
    rd(ADR_FLAGS, 32'h0, "force sets no flag");
    wb(1, ADR_CTRL_B, 32'h0);
    wb(1, ADR_CTRL_A, 32'h1);
    wb(1, ADR_CMP0 + ADR_STEP, 32'h33);
    rd(ADR_CMP0 + ADR_STEP, 32'h33, "buffered read");
  endtask : t_force

  task automatic t_dead;
    wb(1, ADR_TOP, 32'h3f);
    wb(1, ADR_DEAD, 32'h23);
    for (int c = 0; c < NCH; c++) wb(1, 8'(ADR_CMP0 + ADR_STEP * c), 32'h20);
    for (int k = 0; k < 4; k++) begin
      wb(1, ADR_DTPS, 32'h1500 | k);
      wb(1, ADR_CTRL_B, 32'h1);
      clr <= 1'b1;
      wait_lvl(0, 1'b1);
      clr <= 1'b0;
      wait_lvl(0, 1'b0);
      wait_lvl(1, 1'b1);
      // Dead-time divider runs free, so the first step may come early
      cmp(g >= (2 << k) + 1 && g <= (3 << k) + 2, 1, "fall gap");
      wait_lvl(1, 1'b0);
      wait_lvl(0, 1'b1);
      cmp(g >= (1 << k) + 1 && g <= (2 << k) + 2, 1, "rise gap");
      cmp(overlaps, 0, "overlap");
    end
    inv <= 1'b1;
    wb(1, ADR_CTRL_A, 32'h9);
    clr <= 1'b1;
    @(posedge i_clk);
    clr <= 1'b0;
    seen = 0;
    repeat (300) @(posedge i_clk) seen += (out[0] & out_n[0]);
    cmp(seen > 0 && overlaps == 0, 1, "inverted pair");
    wb(1, ADR_CTRL_A, 32'h0);
    inv <= 1'b0;
    // Phase correct: three ticks from 3e turn at top and count down
    wb(1, ADR_CTRL_B, 32'h0);
    wb(1, ADR_CTRL_A, 32'h3);
    wb(1, ADR_COUNTER, 32'h3e);
    wb(1, ADR_CTRL_B, 32'h1);
    wb(1, ADR_CTRL_B, 32'h0);
    rd(ADR_COUNTER, 32'h3d, "phase correct turn");
    wb(1, ADR_CTRL_A, 32'h0);
  endtask : t_dead

  task automatic t_async;
    wb(1, ADR_CTRL_B, 32'h0);
    rd(ADR_PLL, 32'h4, "pll idle");
    repeat (10000) @(posedge i_clk);
    rd(ADR_PLL, 32'h4, "pll locked");
    wb(1, ADR_PLL, 32'h3);
    rd(ADR_PLL, 32'h7, "pll readback");
    cmp(low_speed, 1, "low speed");
    run_cs(8'h01, 50);
    cmp(q, 0, "no fast clock");
    fast_on <= 1'b1;
    run_cs(8'h01, 60);
    cmp(q >= 12 && q <= 20, 1, "fast clock ticks");
  endtask : t_async

  task automatic summarize;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : summarize

  // Watchdog well beyond the expected run
  initial begin
    #400000;
    cmp(0, 1, "timeout");
    summarize();
  end
  // Reset, then the scenarios in turn
  initial begin
    {i_rst, clr} = 2'b11;
    {fast_on, cyc, stb, we, i_irq_ack, inv} = 6'h0;
    {i_irq_ack_ch, adr, wdat} = 42'h0;
    repeat (12) @(posedge i_clk);
    i_rst <= 1'b0;
    clr <= 1'b0;
    t_reset();
    t_prescale();
    t_match();
    t_force();
    t_dead();
    t_async();
    summarize();
  end
endmodule : test_fast_timer
`default_nettype wire
